/* verilog/tvp_pkg.sv */
// shared constants and types for the tv power state controller
package tvp_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ         = 200;
   localparam int POR_TIME_MS     = 110;
   localparam int POR_CYCLES      = POR_TIME_MS * 1000 * CLK_MHZ;
   localparam int RC_MIN_PULSE_US = 8;
   localparam int RC_MIN_CYCLES   = RC_MIN_PULSE_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // operating states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TVP_ST_ON      = 2'b00,
      TVP_ST_STANDBY = 2'b01,
      TVP_ST_OFF     = 2'b10
   } tvp_state_e;

   // ---------------------------------------------------------------
   // command sources
   // ---------------------------------------------------------------
   localparam logic [1:0] SRC_NONE = 2'h0;
   localparam logic [1:0] SRC_KBD  = 2'h1;
   localparam logic [1:0] SRC_RC   = 2'h2;
   localparam logic [1:0] SRC_DATA = 2'h3;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam int          CMD_W         = 6;
   localparam logic [5:0] CMD_EOT       = 6'h00;
   localparam logic [5:0] CMD_STANDBY   = 6'h01;
   localparam logic [5:0] CMD_PROG1     = 6'h03;
   localparam logic [5:0] CMD_PROG2     = 6'h04;
   localparam logic [5:0] CMD_PROG3     = 6'h05;
   localparam logic [5:0] CMD_PROG4     = 6'h06;
   localparam logic [5:0] CMD_PROG5     = 6'h09;
   localparam logic [5:0] CMD_PROG6     = 6'h0A;
   localparam logic [5:0] CMD_PROG7     = 6'h0B;
   localparam logic [5:0] CMD_PROG8     = 6'h0C;
   localparam logic [5:0] CMD_MEM_UP    = 6'h0D;
   localparam logic [5:0] CMD_MEM_DN    = 6'h0E;
   localparam logic [5:0] CMD_PROG9     = 6'h0F;
   localparam logic [5:0] CMD_PROG10    = 6'h10;
   localparam logic [5:0] CMD_DEC_DN    = 6'h11;
   localparam logic [5:0] CMD_DEC_UP    = 6'h12;
   localparam logic [5:0] CMD_ON_STBY   = 6'h14;
   localparam logic [5:0] CMD_STAR      = 6'h15;
   localparam logic [5:0] CMD_PROG14    = 6'h16;
   localparam logic [5:0] CMD_PROG15    = 6'h17;
   localparam logic [5:0] CMD_PROG16    = 6'h18;
   localparam logic [5:0] CMD_ON_OFF    = 6'h3F;

   // ---------------------------------------------------------------
   // remote receiver address
   // ---------------------------------------------------------------
   localparam int          RC_ADDR_W    = 5;
   localparam logic [4:0] RC_SYS_ADDR  = 5'h0A;

   // ---------------------------------------------------------------
   // open-drain output bank layout
   // ---------------------------------------------------------------
   localparam int OD_W       = 14;
   localparam int OD_ANA_LO  = 0;
   localparam int OD_TUNE    = 4;
   localparam int OD_AV_LO   = 5;
   localparam int OD_MS_LO   = 7;
   localparam int OD_AFC     = 9;
   localparam int OD_BAND_LO = 10;
   localparam logic [13:0] OD_BAND_MASK = 14'h3C00;

   // ---------------------------------------------------------------
   // display and pin levels
   // ---------------------------------------------------------------
   localparam int          SEG_W       = 7;
   localparam logic [6:0] SEG_ALL_OFF = 7'h7F;
   localparam logic [6:0] SEG_G_ONLY  = 7'h3F;
   localparam logic       OFF_IND_LVL = 1'b0;

endpackage

/* verilog/tvp_sync3.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module tvp_sync3 #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_level
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } tvp_sync_s;

   tvp_sync_s st_reg;
   tvp_sync_s st_next;

   always_comb begin
      st_next     = st_reg;
      st_next.s1  = i_async;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      // level moves only when the two late stages agree
      if (st_reg.s2 == st_reg.s3) begin
         st_next.lvl = st_reg.s3;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_reg <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_level = st_reg.lvl;

endmodule

/* verilog/tvp_pulse_qual.sv */
// minimum-width pulse qualifier for the remote receiver input
`timescale 1ns/1ps

module tvp_pulse_qual #(
   parameter int MIN_CYCLES = tvp_pkg::RC_MIN_CYCLES
) (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_level,
   output logic      o_pulse
);

   localparam int CW = $clog2(MIN_CYCLES + 1);

   if (MIN_CYCLES < 1) begin : g_chk
      $error("MIN_CYCLES must be at least one");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          seen;
      logic          pulse;
   } tvp_qual_s;

   tvp_qual_s st_reg;
   tvp_qual_s st_next;

   always_comb begin
      st_next       = st_reg;
      st_next.pulse = 1'b0;
      if (!i_level) begin
         st_next.cnt  = '0;
         st_next.seen = 1'b0;
      end else if (!st_reg.seen) begin
         // one report per pulse once it is wide enough
         if (st_reg.cnt == CW'(MIN_CYCLES - 1)) begin
            st_next.seen  = 1'b1;
            st_next.pulse = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_pulse = st_reg.pulse;

endmodule

/* verilog/tvp_power_ctrl.sv */
// operating state controller: power-on reset, on, standby and off
`timescale 1ns/1ps

// Notes on behaviour
// - after the supply comes up an internal reset is held for 110 ms.
// - on drives the display, takes rts as input, standby high, all normal.
// - standby shows only the g segment as a static bar.
// - standby keeps rts as input and drives the standby output low.
// - standby keeps only program, power, memory step, star and decade keys.
// - standby pulls control outputs low and releases the band outputs.
// - off blanks the display, turns rts into an off output, standby low.
// - off disables the display and releases the display drive pin.
// - off accepts no key except on/off.
// - off ignores all remote and data command words.
// - off releases the control outputs so they float high.
// - remote words are taken only when their system address is ten.
module tvp_power_ctrl #(
   parameter int                 POR_CYCLES   = tvp_pkg::POR_CYCLES,
   parameter int                 RC_MIN       = tvp_pkg::RC_MIN_CYCLES,
   parameter tvp_pkg::tvp_state_e START_STATE = tvp_pkg::TVP_ST_STANDBY
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_kbd_valid,
   input  wire logic [5:0]  i_kbd_cmd,
   input  wire logic        i_rc_valid,
   input  wire logic [4:0]  i_rc_addr,
   input  wire logic [5:0]  i_rc_cmd,
   input  wire logic        i_data_valid,
   input  wire logic [5:0]  i_data_cmd,
   input  wire logic        i_rc_pin,
   input  wire logic        i_hs_in,
   input  wire logic [6:0]  i_seg_n,
   input  wire logic [13:0] i_func_level,
   output logic             o_por_busy,
   output logic [1:0]       o_state,
   output logic             o_standby,
   output logic [6:0]       o_seg_n,
   output logic             o_disp_drive_out,
   output logic             o_disp_drive_oe_n,
   output logic             o_hs_out,
   output logic             o_hs_oe_n,
   output logic             o_rts,
   output logic [13:0]      o_od_out,
   output logic [13:0]      o_od_oe_n,
   output logic             o_rc_pulse,
   output logic             o_cmd_valid,
   output logic [5:0]       o_cmd_code,
   output logic [1:0]       o_cmd_src
);

   localparam int PW = $clog2(POR_CYCLES + 1);

   if (POR_CYCLES < 1 || RC_MIN < 1) begin : g_chk
      $error("POR_CYCLES and RC_MIN must be at least one");
   end

   // ---------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------
   typedef struct packed {
      tvp_pkg::tvp_state_e st;
      logic [PW-1:0]       por_cnt;
      logic                por_busy;
      logic                standby;
      logic [6:0]          seg_n;
      logic                disp_oe_n;
      logic                hs_out;
      logic                hs_oe_n;
      logic                rts;
      logic [13:0]         od_oe_n;
      logic                rc_pulse;
      logic                cmd_valid;
      logic [5:0]          cmd_code;
      logic [1:0]          cmd_src;
   } tvp_ctrl_s;

   tvp_ctrl_s st_reg;
   tvp_ctrl_s st_next;

   logic hs_sync;
   logic rc_sync;
   logic rc_pulse;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   tvp_sync3 #(
      .RESET_VAL (1'b1)
   ) u_hs_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async (i_hs_in),
      .o_level (hs_sync)
   );

   tvp_sync3 #(
      .RESET_VAL (1'b0)
   ) u_rc_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async (i_rc_pin),
      .o_level (rc_sync)
   );

   tvp_pulse_qual #(
      .MIN_CYCLES (RC_MIN)
   ) u_rc_qual (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_level (rc_sync),
      .o_pulse (rc_pulse)
   );

   // ---------------------------------------------------------------
   // key filter for standby
   // ---------------------------------------------------------------
   function automatic logic stby_key_ok(input logic [5:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         tvp_pkg::CMD_PROG1,  tvp_pkg::CMD_PROG2,
         tvp_pkg::CMD_PROG3,  tvp_pkg::CMD_PROG4,
         tvp_pkg::CMD_PROG5,  tvp_pkg::CMD_PROG6,
         tvp_pkg::CMD_PROG7,  tvp_pkg::CMD_PROG8,
         tvp_pkg::CMD_PROG9,  tvp_pkg::CMD_PROG10,
         tvp_pkg::CMD_PROG14, tvp_pkg::CMD_PROG15,
         tvp_pkg::CMD_PROG16,
         tvp_pkg::CMD_ON_OFF, tvp_pkg::CMD_ON_STBY,
         tvp_pkg::CMD_MEM_UP, tvp_pkg::CMD_MEM_DN,
         tvp_pkg::CMD_STAR,
         tvp_pkg::CMD_DEC_UP, tvp_pkg::CMD_DEC_DN: begin
            ok = 1'b1;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic                kbd_ok;
      logic                rc_ok;
      logic                data_ok;
      logic                take;
      logic [5:0]          code;
      logic [1:0]          src;
      tvp_pkg::tvp_state_e ns;
      kbd_ok  = 1'b0;
      rc_ok   = 1'b0;
      data_ok = 1'b0;
      take    = 1'b0;
      code    = tvp_pkg::CMD_EOT;
      src     = tvp_pkg::SRC_NONE;
      ns      = st_reg.st;
      st_next = st_reg;

      st_next.rc_pulse = rc_pulse;

      // power-on hold
      if (st_reg.por_busy) begin
         if (st_reg.por_cnt == PW'(POR_CYCLES - 1)) begin
            st_next.por_busy = 1'b0;
         end else begin
            st_next.por_cnt = st_reg.por_cnt + PW'(1);
         end
      end

      // source acceptance per state
      case (st_reg.st)
         tvp_pkg::TVP_ST_ON: begin
            kbd_ok  = i_kbd_valid;
            rc_ok   = i_rc_valid;
            data_ok = i_data_valid;
         end
         tvp_pkg::TVP_ST_STANDBY: begin
            kbd_ok  = i_kbd_valid && stby_key_ok(i_kbd_cmd);
            rc_ok   = i_rc_valid;
            data_ok = i_data_valid;
         end
         tvp_pkg::TVP_ST_OFF: begin
            kbd_ok  = i_kbd_valid
                      && (i_kbd_cmd == tvp_pkg::CMD_ON_OFF);
            rc_ok   = 1'b0;
            data_ok = 1'b0;
         end
         default: begin
            kbd_ok  = 1'b0;
            rc_ok   = 1'b0;
            data_ok = 1'b0;
         end
      endcase
      rc_ok = rc_ok && (i_rc_addr == tvp_pkg::RC_SYS_ADDR);

      // keyboard first, then remote, then data input
      if (st_reg.por_busy) begin
         take = 1'b0;
      end else if (kbd_ok) begin
         take = 1'b1;
         code = i_kbd_cmd;
         src  = tvp_pkg::SRC_KBD;
      end else if (rc_ok) begin
         take = 1'b1;
         code = i_rc_cmd;
         src  = tvp_pkg::SRC_RC;
      end else if (data_ok) begin
         take = 1'b1;
         code = i_data_cmd;
         src  = tvp_pkg::SRC_DATA;
      end
      st_next.cmd_valid = take;
      st_next.cmd_code  = take ? code : tvp_pkg::CMD_EOT;
      st_next.cmd_src   = take ? src : tvp_pkg::SRC_NONE;

      // state changes on toggles only
      if (take && code == tvp_pkg::CMD_ON_OFF) begin
         if (st_reg.st == tvp_pkg::TVP_ST_OFF) begin
            ns = tvp_pkg::TVP_ST_ON;
         end else begin
            ns = tvp_pkg::TVP_ST_OFF;
         end
      end else if (take && code == tvp_pkg::CMD_ON_STBY) begin
         if (st_reg.st == tvp_pkg::TVP_ST_ON) begin
            ns = tvp_pkg::TVP_ST_STANDBY;
         end else if (st_reg.st == tvp_pkg::TVP_ST_STANDBY) begin
            ns = tvp_pkg::TVP_ST_ON;
         end
      end
      st_next.st = ns;

      // pin and display levels for the coming state
      case (ns)
         tvp_pkg::TVP_ST_ON: begin
            st_next.seg_n     = i_seg_n;
            st_next.disp_oe_n = 1'b0;
            st_next.hs_oe_n   = 1'b1;
            st_next.rts       = hs_sync;
            st_next.standby   = 1'b1;
            st_next.od_oe_n   = i_func_level;
         end
         tvp_pkg::TVP_ST_STANDBY: begin
            st_next.seg_n     = tvp_pkg::SEG_G_ONLY;
            st_next.disp_oe_n = 1'b0;
            st_next.hs_oe_n   = 1'b1;
            st_next.rts       = hs_sync;
            st_next.standby   = 1'b0;
            st_next.od_oe_n   = tvp_pkg::OD_BAND_MASK;
         end
         tvp_pkg::TVP_ST_OFF: begin
            st_next.seg_n     = tvp_pkg::SEG_ALL_OFF;
            st_next.disp_oe_n = 1'b1;
            st_next.hs_oe_n   = 1'b0;
            st_next.rts       = 1'b0;
            st_next.standby   = 1'b0;
            st_next.od_oe_n   = '1;
         end
         default: begin
            st_next.seg_n     = tvp_pkg::SEG_ALL_OFF;
            st_next.disp_oe_n = 1'b1;
            st_next.hs_oe_n   = 1'b1;
            st_next.rts       = 1'b0;
            st_next.standby   = 1'b0;
            st_next.od_oe_n   = '1;
         end
      endcase
      st_next.hs_out = tvp_pkg::OFF_IND_LVL;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_reg.st        <= START_STATE;
         st_reg.por_cnt   <= '0;
         st_reg.por_busy  <= 1'b1;
         st_reg.standby   <= 1'b0;
         st_reg.seg_n     <= tvp_pkg::SEG_ALL_OFF;
         st_reg.disp_oe_n <= 1'b1;
         st_reg.hs_out    <= tvp_pkg::OFF_IND_LVL;
         st_reg.hs_oe_n   <= 1'b1;
         st_reg.rts       <= 1'b0;
         st_reg.od_oe_n   <= '1;
         st_reg.rc_pulse  <= 1'b0;
         st_reg.cmd_valid <= 1'b0;
         st_reg.cmd_code  <= tvp_pkg::CMD_EOT;
         st_reg.cmd_src   <= tvp_pkg::SRC_NONE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_por_busy        = st_reg.por_busy;
   assign o_state           = st_reg.st;
   assign o_standby         = st_reg.standby;
   assign o_seg_n           = st_reg.seg_n;
   assign o_disp_drive_out  = 1'b0;
   assign o_disp_drive_oe_n = st_reg.disp_oe_n;
   assign o_hs_out          = st_reg.hs_out;
   assign o_hs_oe_n         = st_reg.hs_oe_n;
   assign o_rts             = st_reg.rts;
   assign o_od_out          = '0;
   assign o_od_oe_n         = st_reg.od_oe_n;
   assign o_rc_pulse        = st_reg.rc_pulse;
   assign o_cmd_valid       = st_reg.cmd_valid;
   assign o_cmd_code        = st_reg.cmd_code;
   assign o_cmd_src         = st_reg.cmd_src;

endmodule

/* tb/tvp_ctrl_monitor.sv */
// assertion checker for the power state controller
`timescale 1ns/1ps

module tvp_ctrl_monitor #(
   parameter int POR_CYCLES = 20
) (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        i_kbd_valid,
   input wire logic [5:0]  i_kbd_cmd,
   input wire logic        i_rc_valid,
   input wire logic [4:0]  i_rc_addr,
   input wire logic        i_data_valid,
   input wire logic        o_por_busy,
   input wire logic [1:0]  o_state,
   input wire logic        o_standby,
   input wire logic [6:0]  o_seg_n,
   input wire logic        o_disp_drive_oe_n,
   input wire logic        o_hs_out,
   input wire logic        o_hs_oe_n,
   input wire logic [13:0] o_od_oe_n,
   input wire logic        o_cmd_valid,
   input wire logic [5:0]  o_cmd_code,
   input wire logic [1:0]  o_cmd_src
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   sequence s_in_stby;
      o_state == tvp_pkg::TVP_ST_STANDBY && !$past(i_rst);
   endsequence
   sequence s_cmd_off;
      o_cmd_valid && $past(o_state) == tvp_pkg::TVP_ST_OFF;
   endsequence
   sequence s_cmd_stby;
      o_cmd_valid && $past(o_state) == tvp_pkg::TVP_ST_STANDBY;
   endsequence
   sequence s_stby_key;
      o_state == tvp_pkg::TVP_ST_ON && !o_por_busy && i_kbd_valid
         && i_kbd_cmd == tvp_pkg::CMD_ON_STBY;
   endsequence

   property p_por;
      $fell(i_rst) |-> o_por_busy [*8] ##[0:POR_CYCLES] !o_por_busy;
   endproperty
   a_por: assert property (p_por) else $error("por hold wrong");
   property p_por_cmd;
      o_cmd_valid |-> !$past(o_por_busy);
   endproperty
   a_por_cmd: assert property (p_por_cmd) else $error("cmd in por");
   property p_on;
      o_state == tvp_pkg::TVP_ST_ON |-> o_standby && o_hs_oe_n
         && !o_disp_drive_oe_n;
   endproperty
   a_on: assert property (p_on) else $error("on levels");
   property p_stby;
      s_in_stby |-> o_seg_n == tvp_pkg::SEG_G_ONLY && !o_standby
         && o_hs_oe_n;
   endproperty
   a_stby: assert property (p_stby) else $error("stby pins");
   property p_stby_od;
      s_in_stby |-> o_od_oe_n == tvp_pkg::OD_BAND_MASK;
   endproperty
   a_stby_od: assert property (p_stby_od) else $error("stby od");
   property p_off;
      o_state == tvp_pkg::TVP_ST_OFF |-> o_seg_n == tvp_pkg::SEG_ALL_OFF
         && o_disp_drive_oe_n && !o_hs_oe_n && !o_standby
         && o_hs_out == tvp_pkg::OFF_IND_LVL;
   endproperty
   a_off: assert property (p_off) else $error("off pins");
   property p_off_od;
      o_state == tvp_pkg::TVP_ST_OFF |-> &o_od_oe_n;
   endproperty
   a_off_od: assert property (p_off_od) else $error("off od");
   property p_off_cmd;
      s_cmd_off |-> o_cmd_src == tvp_pkg::SRC_KBD
         && o_cmd_code == tvp_pkg::CMD_ON_OFF;
   endproperty
   a_off_cmd: assert property (p_off_cmd) else $error("off cmd");
   property p_stby_cmd;
      s_cmd_stby |-> o_cmd_src != tvp_pkg::SRC_KBD || o_cmd_code inside
         {[6'h03:6'h06], [6'h09:6'h12], [6'h14:6'h18], 6'h3F};
   endproperty
   a_stby_cmd: assert property (p_stby_cmd) else $error("stby cmd");
   property p_rc_addr;
      i_rc_valid && i_rc_addr != tvp_pkg::RC_SYS_ADDR && !i_kbd_valid
         && !i_data_valid |=> !o_cmd_valid;
   endproperty
   a_rc_addr: assert property (p_rc_addr) else $error("rc addr");
   property p_toggle;
      $changed(o_state) |-> o_cmd_valid && (o_cmd_code ==
         tvp_pkg::CMD_ON_OFF || o_cmd_code == tvp_pkg::CMD_ON_STBY);
   endproperty
   a_toggle: assert property (p_toggle) else $error("state move");
   property p_stby_key;
      s_stby_key |=> o_state == tvp_pkg::TVP_ST_STANDBY && o_cmd_valid;
   endproperty
   a_stby_key: assert property (p_stby_key) else $error("toggle");
endmodule

/* tb/tvp_far_model.sv */
// keyboard, remote receiver and data source model
`timescale 1ns/1ps

module tvp_far_model (
   input  wire logic i_mclk,
   output logic       o_kbd_valid,
   output logic [5:0] o_kbd_cmd,
   output logic       o_rc_valid,
   output logic [4:0] o_rc_addr,
   output logic [5:0] o_rc_cmd,
   output logic       o_data_valid,
   output logic [5:0] o_data_cmd,
   output logic       o_rc_pin
);
   // ---------------------------------------------------------------
   // sources
   // ---------------------------------------------------------------
   initial begin
      {o_kbd_valid, o_rc_valid, o_data_valid, o_rc_pin} = 4'h0;
      {o_kbd_cmd, o_rc_cmd, o_data_cmd, o_rc_addr} = 23'h0;
   end
   // mask bit0 keyboard, bit1 remote, bit2 data
   task automatic send(input logic [2:0] mask, input logic [5:0] cmd,
                       input logic [4:0] addr);
      @(posedge i_mclk);
      #1;
      {o_data_valid, o_rc_valid, o_kbd_valid} = mask;
      {o_kbd_cmd, o_rc_cmd, o_data_cmd} = {3{cmd}};
      o_rc_addr = addr;
      @(posedge i_mclk);
      #1;
      {o_data_valid, o_rc_valid, o_kbd_valid} = 3'h0;
      {o_kbd_cmd, o_rc_cmd, o_data_cmd} = {3{~cmd}};
      o_rc_addr = ~addr;
   endtask
   // pulse on the remote pin, len cycles wide
   task automatic rc_burst(input int len);
      @(posedge i_mclk);
      #1;
      o_rc_pin = 1'b1;
      repeat (len) @(posedge i_mclk);
      #1;
      o_rc_pin = 1'b0;
   endtask
endmodule

/* tb/test_tv_control_power_state_logic.sv */
// testbench for the power state controller
`timescale 1ns/1ps

bind tvp_power_ctrl tvp_ctrl_monitor #(.POR_CYCLES(POR_CYCLES)) mon_u (.*);

module test_tv_control_power_state_logic;
   localparam int POR = 20;
   localparam int RCM = 8;
   typedef struct packed {
      logic [2:0] mask;
      logic [5:0] cmd;
      logic [4:0] addr;
      logic       vld;
      logic [1:0] src;
      logic [1:0] st;
   } tvp_row_s;
   logic        i_mclk, i_rst, hs_lvl, hs_wire, i_kbd_valid, i_rc_valid;
   logic        i_data_valid, i_rc_pin, o_por_busy, o_standby, o_rts;
   logic        o_hs_out, o_hs_oe_n, o_disp_drive_oe_n, o_rc_pulse;
   logic        o_cmd_valid;
   logic [1:0]  o_state, o_cmd_src;
   logic [4:0]  i_rc_addr;
   logic [5:0]  i_kbd_cmd, i_rc_cmd, i_data_cmd, o_cmd_code;
   logic [6:0]  o_seg_n;
   logic [13:0] o_od_oe_n;
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          rc_cnt = 0;
   logic [6:0]  seg_lvl = 7'h12;
   logic [13:0] func_lvl = 14'h2A5C;
   tvp_row_s    rows [20] = '{
      '{3'h1, 6'h03, 5'h0A, 1'b1, 2'h1, 2'h1},
      '{3'h1, 6'h01, 5'h0A, 1'b0, 2'h0, 2'h1},
      '{3'h2, 6'h14, 5'h0A, 1'b1, 2'h2, 2'h0},
      '{3'h4, 6'h14, 5'h0A, 1'b1, 2'h3, 2'h1},
      '{3'h1, 6'h14, 5'h0A, 1'b1, 2'h1, 2'h0},
      '{3'h2, 6'h03, 5'h0B, 1'b0, 2'h0, 2'h0},
      '{3'h2, 6'h03, 5'h0A, 1'b1, 2'h2, 2'h0},
      '{3'h4, 6'h04, 5'h0A, 1'b1, 2'h3, 2'h0},
      '{3'h7, 6'h05, 5'h0A, 1'b1, 2'h1, 2'h0},
      '{3'h6, 6'h06, 5'h0A, 1'b1, 2'h2, 2'h0},
      '{3'h1, 6'h01, 5'h0A, 1'b1, 2'h1, 2'h0},
      '{3'h1, 6'h3F, 5'h0A, 1'b1, 2'h1, 2'h2},
      '{3'h1, 6'h03, 5'h0A, 1'b0, 2'h0, 2'h2},
      '{3'h1, 6'h14, 5'h0A, 1'b0, 2'h0, 2'h2},
      '{3'h2, 6'h3F, 5'h0A, 1'b0, 2'h0, 2'h2},
      '{3'h4, 6'h3F, 5'h0A, 1'b0, 2'h0, 2'h2},
      '{3'h1, 6'h3F, 5'h0A, 1'b1, 2'h1, 2'h0},
      '{3'h2, 6'h14, 5'h0A, 1'b1, 2'h2, 2'h1},
      '{3'h1, 6'h3F, 5'h0A, 1'b1, 2'h1, 2'h2},
      '{3'h1, 6'h3F, 5'h0A, 1'b1, 2'h1, 2'h0}};

   // ---------------------------------------------------------------
   // harness
   // ---------------------------------------------------------------
   assign hs_wire = o_hs_oe_n ? hs_lvl : o_hs_out;

   tvp_far_model far_u (
      .i_mclk(i_mclk), .o_kbd_valid(i_kbd_valid), .o_kbd_cmd(i_kbd_cmd),
      .o_rc_valid(i_rc_valid), .o_rc_addr(i_rc_addr), .o_rc_cmd(i_rc_cmd),
      .o_data_valid(i_data_valid), .o_data_cmd(i_data_cmd),
      .o_rc_pin(i_rc_pin));

   tvp_power_ctrl #(.POR_CYCLES(POR), .RC_MIN(RCM)) dut_u (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_kbd_valid(i_kbd_valid),
      .i_kbd_cmd(i_kbd_cmd), .i_rc_valid(i_rc_valid),
      .i_rc_addr(i_rc_addr), .i_rc_cmd(i_rc_cmd),
      .i_data_valid(i_data_valid), .i_data_cmd(i_data_cmd),
      .i_rc_pin(i_rc_pin), .i_hs_in(hs_wire), .i_seg_n(seg_lvl),
      .i_func_level(func_lvl), .o_por_busy(o_por_busy),
      .o_state(o_state), .o_standby(o_standby), .o_seg_n(o_seg_n),
      .o_disp_drive_out(), .o_disp_drive_oe_n(o_disp_drive_oe_n),
      .o_hs_out(o_hs_out), .o_hs_oe_n(o_hs_oe_n), .o_rts(o_rts),
      .o_od_out(), .o_od_oe_n(o_od_oe_n), .o_rc_pulse(o_rc_pulse),
      .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code),
      .o_cmd_src(o_cmd_src));

   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) begin
      if (o_rc_pulse === 1'b1) rc_cnt <= rc_cnt + 1;
   end

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic check_pins(input logic [1:0] st);
      logic on, off;
      on = (st == 2'h0);
      off = (st == 2'h2);
      check("state", o_state, st);
      check("standby", o_standby, on);
      check("hs_oe_n", o_hs_oe_n, !off);
      check("disp_oe_n", o_disp_drive_oe_n, off);
      check("seg_n", o_seg_n, on ? seg_lvl : off ? 7'h7F : 7'h3F);
      check("od_oe_n", o_od_oe_n, on ? func_lvl : off ? 14'h3FFF
            : 14'h3C00);
      if (off) check("rts", o_rts, 1'b0);
   endtask

   task automatic do_reset(input int n);
      int t;
      i_rst = 1'b1;
      repeat (n) @(posedge i_mclk);
      #1;
      check("rst_state", o_state, 2'h1);
      check("rst_od", o_od_oe_n, 14'h3FFF);
      i_rst = 1'b0;
      far_u.send(3'h1, 6'h14, 5'h0A);
      check("por_cmd", o_cmd_valid, 1'b0);
      t = 2;
      while (o_por_busy === 1'b1 && t < 200) begin
         @(posedge i_mclk);
         #1;
         t++;
      end
      check("por_len", t >= POR - 1 && t <= POR + 1, 1'b1);
      check_pins(2'h1);
   endtask

   task automatic finish_test;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #50000;
      error_cnt++;
      finish_test();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      logic [5:0] c;
      i_rst = 1'b1;
      hs_lvl = 1'b1;
      do_reset(16);
      foreach (rows[i]) begin
         far_u.send(rows[i].mask, rows[i].cmd, rows[i].addr);
         check("valid", o_cmd_valid, rows[i].vld);
         check("src", o_cmd_src, rows[i].src);
         check("code", o_cmd_code, rows[i].vld ? rows[i].cmd : 6'h00);
         check_pins(rows[i].st);
      end
      far_u.send(3'h1, 6'h14, 5'h0A);
      for (int i = 0; i < 64; i++) begin
         c = i[5:0];
         if (c != 6'h14 && c != 6'h3F) begin
            far_u.send(3'h1, c, 5'h0A);
            check("stby_key", o_cmd_valid, c inside {[6'h03:6'h06],
                  [6'h09:6'h12], [6'h14:6'h18]});
         end
      end
      far_u.send(3'h1, 6'h14, 5'h0A);
      hs_lvl = 1'b0;
      repeat (8) @(posedge i_mclk);
      #1;
      check("rts_lo", o_rts, 1'b0);
      hs_lvl = 1'b1;
      repeat (8) @(posedge i_mclk);
      #1;
      check("rts_hi", o_rts, 1'b1);
      far_u.rc_burst(RCM - 4);
      repeat (20) @(posedge i_mclk);
      check("rc_short", rc_cnt, 16'h0);
      far_u.rc_burst(RCM + 6);
      repeat (20) @(posedge i_mclk);
      #1;
      check("rc_long", rc_cnt, 16'h1);
      do_reset(2);
      finish_test();
   end
endmodule
